/* ami_mem.sv */
// Behavioural byte-enabled asynchronous memory with a wait output.
// Assumes active-low selects and strobes that change on aclk edges.
`timescale 1ns/1ps
module ami_mem
(
	input  wire logic        aclk,
	input  wire logic [12:0] addr,
	input  wire logic        cs_n,
	input  wire logic        we_n,
	input  wire logic        re_n,
	input  wire logic [3:0]  be_n,
	input  wire logic [31:0] din,
	output logic      [31:0] dout,
	output logic             wait_pin,
	input  wire logic        wait_lvl,
	input  var  int          wait_len
);
	logic [31:0] mem [16];
	logic [31:0] last = 32'h00000000;
	logic        stb_q = 1'b0;
	int          cnt = 0;
	initial
		foreach (mem[i]) mem[i] = 32'h00000000;
	// Byte enables wired to the strobe pins, never tied low, so byte writes work
	// Only low address lines decode; upper lines are taken as held low
	always @(posedge aclk)
	begin
		if (!we_n && !cs_n)
			for (int i = 0; i < 4; i++)
				if (!be_n[i]) mem[addr[3:0]][8*i+:8] <= din[8*i+:8];
		stb_q <= !we_n || !re_n;
		if ((!we_n || !re_n) && !stb_q)
			cnt <= wait_len;
		else if (cnt > 0)
			cnt <= cnt - 1;
		last <= dout;
	end
	// Released bus toggles each cycle, so the last read value reappears only on every second released cycle
	assign dout = (!re_n && !cs_n) ? mem[addr[3:0]] : ~last;
	// Not a NAND part, so extended wait is legal here
	assign wait_pin = (cnt > 0) ? wait_lvl : !wait_lvl;
endmodule

/* ami_pkg.sv */
// Constants for the asynchronous memory interface: register map, fields, reset values, states.
// Assumes a 32-bit AXI4-Lite register bus and one controller clock.
package ami_pkg;
	localparam logic [7:0] OFF_TIMING = 8'h00;
	localparam logic [7:0] OFF_WAIT   = 8'h04;
	localparam logic [7:0] OFF_ADDR   = 8'h08;
	localparam logic [7:0] OFF_WDATA  = 8'h0C;
	localparam logic [7:0] OFF_CMD    = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_RDATA  = 8'h18;

	localparam int POS_SS     = 31;
	localparam int POS_EW     = 30;
	localparam int POS_WSETUP = 26;
	localparam int POS_WSTRB  = 20;
	localparam int POS_WHOLD  = 17;
	localparam int POS_RSETUP = 13;
	localparam int POS_RSTRB  = 7;
	localparam int POS_RHOLD  = 4;
	localparam int POS_TA     = 2;
	localparam int POS_ASIZE  = 0;
	localparam int POS_WP     = 28;
	localparam int POS_START  = 0;
	localparam int POS_WRITE  = 1;
	localparam int POS_BE     = 4;
	localparam int POS_BUSY   = 0;

	localparam int SETUP_W = 4;
	localparam int STRB_W  = 6;
	localparam int HOLD_W  = 3;
	localparam int CNT_W   = 6;

	localparam logic [31:0] RST_TIMING = 32'h3FFFFFFC;
	localparam logic [31:0] RST_WAIT   = 32'h10000000;
	localparam logic [31:0] TIMING_MASK = 32'hFFFFFFFF;
	localparam logic [31:0] WAIT_MASK   = 32'h10000000;

	localparam logic [1:0] ASIZE_8  = 2'h0;
	localparam logic [1:0] ASIZE_16 = 2'h1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		AMI_IDLE   = 2'b00,
		AMI_SETUP  = 2'b01,
		AMI_STROBE = 2'b10,
		AMI_HOLD   = 2'b11
	} ami_state_t;
endpackage

/* ami_top.sv */
// Asynchronous memory interface: AXI4-Lite registers and an access engine for SRAM or flash.
// Assumes synchronous inputs on aclk and one access in flight, started by a command write.
`timescale 1ns/1ps
module ami_top
#(
	parameter int ADDR_W = 13
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [ADDR_W-1:0]      ext_word_addr,
	output logic [1:0]             byte_lane_select,
	output logic [3:0]             write_strobe_byte_enable_n,
	output logic                   async_chip_select_n,
	output logic                   write_strobe_pin_n,
	output logic                   read_strobe_n,
	output logic [31:0]            ext_data_out,
	output logic                   ext_data_oe,
	input  wire logic [31:0]       ext_data_in,
	input  wire logic              wait_input_pin
);
	logic [31:0]        async_timing_config, next_timing;
	logic [31:0]        wait_cycle_config, next_wait;
	logic [31:0]        mem_addr, next_mem_addr;
	logic [31:0]        mem_wdata, next_mem_wdata;
	logic               aw_full, next_aw_full;
	logic [7:0]         aw_addr, next_aw_addr;
	logic               w_full, next_w_full;
	logic [31:0]        w_data, next_w_data;
	logic [3:0]         w_strb, next_w_strb;
	logic               next_awready, next_wready, next_arready;
	logic               next_bvalid, next_rvalid;
	logic [1:0]         next_bresp, next_rresp;
	logic [31:0]        next_rdata;
	logic               start, next_start;
	logic               start_write, next_start_write;
	logic [3:0]         start_be, next_start_be;
	logic [31:0]        wmask;

	localparam int CNT_W_L = ami_pkg::CNT_W;

	ami_pkg::ami_state_t state, next_state;
	logic [CNT_W_L-1:0] cnt, next_cnt;
	logic [31:0]        snap, next_snap;
	logic               snap_wp, next_snap_wp;
	logic               acc_wr, next_acc_wr;
	logic [3:0]         acc_be, next_acc_be;
	logic [31:0]        acc_addr, next_acc_addr;
	logic [31:0]        acc_data, next_acc_data;
	logic [31:0]        read_data, next_read_data;
	logic [ADDR_W-1:0]  next_ext_addr;
	logic [1:0]         next_bls;
	logic [3:0]         next_dqm_n;
	logic               next_cs_n, next_we_n, next_re_n, next_oe;
	logic               wait_act;
	logic               busy;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	assign busy = (state != ami_pkg::AMI_IDLE) || start;

	// Register bus: address and data are taken independently, the write happens once both are held
	always_comb
	begin
		next_timing      = async_timing_config;
		next_wait        = wait_cycle_config;
		next_mem_addr    = mem_addr;
		next_mem_wdata   = mem_wdata;
		next_aw_full     = aw_full;
		next_aw_addr     = aw_addr;
		next_w_full      = w_full;
		next_w_data      = w_data;
		next_w_strb      = w_strb;
		next_bvalid      = s_axi_bvalid;
		next_bresp       = s_axi_bresp;
		next_rvalid      = s_axi_rvalid;
		next_rresp       = s_axi_rresp;
		next_rdata       = s_axi_rdata;
		next_start       = 1'b0;
		next_start_write = start_write;
		next_start_be    = start_be;
		wmask            = 32'h00000000;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (aw_full && w_full && !s_axi_bvalid)
		begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = ami_pkg::RESP_OKAY;
			unique case (aw_addr)
				ami_pkg::OFF_TIMING: next_timing = merge(async_timing_config, w_data,
					w_strb);
				ami_pkg::OFF_WAIT:
				begin
					wmask     = merge(32'h00000000, ami_pkg::WAIT_MASK, w_strb);
					next_wait = (wait_cycle_config & ~wmask) | (w_data & wmask);
				end
				ami_pkg::OFF_ADDR:   next_mem_addr  = merge(mem_addr, w_data, w_strb);
				ami_pkg::OFF_WDATA:  next_mem_wdata = merge(mem_wdata, w_data, w_strb);
				ami_pkg::OFF_CMD:
				begin
					// A command while an access runs is dropped; software polls busy first
					if (w_strb[0] && w_data[ami_pkg::POS_START] && !busy)
					begin
						next_start       = 1'b1;
						next_start_write = w_data[ami_pkg::POS_WRITE];
						next_start_be    = w_data[ami_pkg::POS_BE +: 4];
					end
				end
				ami_pkg::OFF_STATUS, ami_pkg::OFF_RDATA: ;
				default: next_bresp = ami_pkg::RESP_SLVERR;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = ami_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				ami_pkg::OFF_TIMING: next_rdata = async_timing_config;
				ami_pkg::OFF_WAIT:   next_rdata = wait_cycle_config;
				ami_pkg::OFF_ADDR:   next_rdata = mem_addr;
				ami_pkg::OFF_WDATA:  next_rdata = mem_wdata;
				ami_pkg::OFF_CMD:    next_rdata = 32'h00000000;
				ami_pkg::OFF_STATUS: next_rdata = {31'h00000000, busy};
				ami_pkg::OFF_RDATA:  next_rdata = read_data;
				default:
				begin
					next_rdata = 32'h00000000;
					next_rresp = ami_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_awready = !next_aw_full;
		next_wready  = !next_w_full;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			async_timing_config <= ami_pkg::RST_TIMING;
			wait_cycle_config   <= ami_pkg::RST_WAIT;
			mem_addr            <= 32'h00000000;
			mem_wdata           <= 32'h00000000;
			aw_full             <= 1'b0;
			aw_addr             <= 8'h00;
			w_full              <= 1'b0;
			w_data              <= 32'h00000000;
			w_strb              <= 4'h0;
			s_axi_awready       <= 1'b0;
			s_axi_wready        <= 1'b0;
			s_axi_arready       <= 1'b0;
			s_axi_bvalid        <= 1'b0;
			s_axi_bresp         <= 2'h0;
			s_axi_rvalid        <= 1'b0;
			s_axi_rresp         <= 2'h0;
			s_axi_rdata         <= 32'h00000000;
			start               <= 1'b0;
			start_write         <= 1'b0;
			start_be            <= 4'h0;
		end
		else
		begin
			async_timing_config <= next_timing;
			wait_cycle_config   <= next_wait;
			mem_addr            <= next_mem_addr;
			mem_wdata           <= next_mem_wdata;
			aw_full             <= next_aw_full;
			aw_addr             <= next_aw_addr;
			w_full              <= next_w_full;
			w_data              <= next_w_data;
			w_strb              <= next_w_strb;
			s_axi_awready       <= next_awready;
			s_axi_wready        <= next_wready;
			s_axi_arready       <= next_arready;
			s_axi_bvalid        <= next_bvalid;
			s_axi_bresp         <= next_bresp;
			s_axi_rvalid        <= next_rvalid;
			s_axi_rresp         <= next_rresp;
			s_axi_rdata         <= next_rdata;
			start               <= next_start;
			start_write         <= next_start_write;
			start_be            <= next_start_be;
		end
	end

	// Polarity one waits on a high pin, zero on a low pin
	assign wait_act = snap_wp ? wait_input_pin : !wait_input_pin;

	// Access engine; the configuration is snapshotted at start so a mid-access write cannot tear it
	always_comb
	begin
		next_state     = state;
		next_cnt       = cnt;
		next_snap      = snap;
		next_snap_wp   = snap_wp;
		next_acc_wr    = acc_wr;
		next_acc_be    = acc_be;
		next_acc_addr  = acc_addr;
		next_acc_data  = acc_data;
		next_read_data = read_data;
		unique case (state)
			ami_pkg::AMI_IDLE:
				if (start)
				begin
					next_snap     = async_timing_config;
					next_snap_wp  = wait_cycle_config[ami_pkg::POS_WP];
					next_acc_wr   = start_write;
					next_acc_be   = start_be;
					next_acc_addr = mem_addr;
					next_acc_data = mem_wdata;
					next_state    = ami_pkg::AMI_SETUP;
					next_cnt      = start_write ?
						CNT_W_L'(async_timing_config[ami_pkg::POS_WSETUP +: ami_pkg::SETUP_W]) :
						CNT_W_L'(async_timing_config[ami_pkg::POS_RSETUP +: ami_pkg::SETUP_W]);
				end
			ami_pkg::AMI_SETUP:
				if (cnt == '0)
				begin
					next_state = ami_pkg::AMI_STROBE;
					next_cnt   = acc_wr ? snap[ami_pkg::POS_WSTRB +: ami_pkg::STRB_W] :
						snap[ami_pkg::POS_RSTRB +: ami_pkg::STRB_W];
				end
				else
					next_cnt = cnt - 1'b1;
			ami_pkg::AMI_STROBE:
				if (cnt != '0)
					next_cnt = cnt - 1'b1;
				else if (!(snap[ami_pkg::POS_EW] && wait_act))
				begin
					if (!acc_wr)
						next_read_data = ext_data_in;
					next_state = ami_pkg::AMI_HOLD;
					next_cnt   = acc_wr ?
						CNT_W_L'(snap[ami_pkg::POS_WHOLD +: ami_pkg::HOLD_W]) :
						CNT_W_L'(snap[ami_pkg::POS_RHOLD +: ami_pkg::HOLD_W]);
				end
			ami_pkg::AMI_HOLD:
				if (cnt == '0)
					next_state = ami_pkg::AMI_IDLE;
				else
					next_cnt = cnt - 1'b1;
		endcase
		next_ext_addr = next_acc_addr[ADDR_W+1:2];
		unique case (next_snap[ami_pkg::POS_ASIZE +: 2])
			ami_pkg::ASIZE_8:  next_bls = next_acc_addr[1:0];
			ami_pkg::ASIZE_16: next_bls = {next_acc_addr[1], 1'b0};
			default:           next_bls = 2'h0;
		endcase
		next_we_n  = !(next_acc_wr && next_state == ami_pkg::AMI_STROBE);
		next_re_n  = !(!next_acc_wr && next_state == ami_pkg::AMI_STROBE);
		next_oe    = next_acc_wr && next_state != ami_pkg::AMI_IDLE;
		next_dqm_n = 4'hF;
		if (next_snap[ami_pkg::POS_SS])
		begin
			next_cs_n = next_state != ami_pkg::AMI_STROBE;
			if (next_state != ami_pkg::AMI_IDLE)
				next_dqm_n = ~next_acc_be;
		end
		else
		begin
			next_cs_n = next_state == ami_pkg::AMI_IDLE;
			if (!next_we_n)
				next_dqm_n = ~next_acc_be;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state                      <= ami_pkg::AMI_IDLE;
			cnt                        <= '0;
			snap                       <= ami_pkg::RST_TIMING;
			snap_wp                    <= 1'b0;
			acc_wr                     <= 1'b0;
			acc_be                     <= 4'h0;
			acc_addr                   <= 32'h00000000;
			acc_data                   <= 32'h00000000;
			read_data                  <= 32'h00000000;
			ext_word_addr              <= '0;
			byte_lane_select           <= 2'h0;
			write_strobe_byte_enable_n <= 4'hF;
			async_chip_select_n        <= 1'b1;
			write_strobe_pin_n         <= 1'b1;
			read_strobe_n              <= 1'b1;
			ext_data_out               <= 32'h00000000;
			ext_data_oe                <= 1'b0;
		end
		else
		begin
			state                      <= next_state;
			cnt                        <= next_cnt;
			snap                       <= next_snap;
			snap_wp                    <= next_snap_wp;
			acc_wr                     <= next_acc_wr;
			acc_be                     <= next_acc_be;
			acc_addr                   <= next_acc_addr;
			acc_data                   <= next_acc_data;
			read_data                  <= next_read_data;
			ext_word_addr              <= next_ext_addr;
			byte_lane_select           <= next_bls;
			write_strobe_byte_enable_n <= next_dqm_n;
			async_chip_select_n        <= next_cs_n;
			write_strobe_pin_n         <= next_we_n;
			read_strobe_n              <= next_re_n;
			ext_data_out               <= next_acc_data;
			ext_data_oe                <= next_oe;
		end
	end
endmodule

/* ami_top_assertions.sv */
// Checker for the external pins of ami_top.
// Assumes it is bound to ami_top and sees only its ports.
`timescale 1ns/1ps
module ami_top_assertions
#(
	parameter int ADDR_W = 13
)
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] ext_word_addr,
	input wire logic [3:0]        write_strobe_byte_enable_n,
	input wire logic              async_chip_select_n,
	input wire logic              write_strobe_pin_n,
	input wire logic              read_strobe_n,
	input wire logic              ext_data_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	strobe_excl_a: assert property (!(!write_strobe_pin_n && !read_strobe_n))
		else $error("both strobes low");
	we_select_a: assert property (!write_strobe_pin_n |-> !async_chip_select_n && ext_data_oe)
		else $error("write strobe without select or data");
	re_select_a: assert property (!read_strobe_n |-> !async_chip_select_n && !ext_data_oe)
		else $error("read strobe without select or with data driven");
	we_setup_a: assert property ($fell(write_strobe_pin_n) |-> $past(ext_data_oe))
		else $error("write data not set up before strobe");
	re_setup_a: assert property ($fell(read_strobe_n) |->
		!$past(async_chip_select_n) || $past(write_strobe_byte_enable_n) != 4'hF)
		else $error("no setup phase before read strobe");
	addr_stable_a: assert property ((!write_strobe_pin_n || !read_strobe_n) |-> $stable(ext_word_addr))
		else $error("address moved during strobe");
	wr_hold_a: assert property ($rose(write_strobe_pin_n) |-> ext_data_oe && $stable(ext_word_addr))
		else $error("write hold not kept");
	strobe_end_a: assert property ($fell(write_strobe_pin_n) |-> ##[1:80] write_strobe_pin_n)
		else $error("write strobe too long");
endmodule

bind ami_top ami_top_assertions #(.ADDR_W(ADDR_W)) u_ami_top_assertions (
	.aclk(aclk), .aresetn(aresetn), .ext_word_addr(ext_word_addr),
	.write_strobe_byte_enable_n(write_strobe_byte_enable_n),
	.async_chip_select_n(async_chip_select_n), .write_strobe_pin_n(write_strobe_pin_n),
	.read_strobe_n(read_strobe_n), .ext_data_oe(ext_data_oe));

/* tb_ami_top.sv */
// Self-checking bench for ami_top with a behavioural memory on its far side.
// Assumes ami_mem and the bound checker are compiled before it.
`timescale 1ns/1ps
module tb_ami_top;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, wait_lvl = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'hF;
	int          wait_len = 0, num_errors = 0, tests_run = 0;
	logic        awready, wready, bvalid, arready, rvalid, csn, wen, ren, oe, wt;
	logic [1:0]  bresp, rresp, bl;
	logic [31:0] rdata, dout, din;
	logic [3:0]  ben;
	logic [12:0] wa;

	always #5 aclk = ~aclk;

	ami_top u_ami_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_word_addr(wa), .byte_lane_select(bl),
		.write_strobe_byte_enable_n(ben), .async_chip_select_n(csn),
		.write_strobe_pin_n(wen), .read_strobe_n(ren), .ext_data_out(dout),
		.ext_data_oe(oe), .ext_data_in(din), .wait_input_pin(wt));
	ami_mem u_ami_mem (.aclk(aclk), .addr(wa), .cs_n(csn), .we_n(wen), .re_n(ren),
		.be_n(ben), .din(dout), .dout(din), .wait_pin(wt), .wait_lvl(wait_lvl),
		.wait_len(wait_len));

	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			$display("unexpected %s: expected %h, seen %h", n, e, g);
			num_errors++;
		end
	endtask

	task automatic conclude;
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 100);
		r = bresp;
		bready <= 1'b0;
		if (!bvalid) chk("write response", 32'h1, 32'h0);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (!rvalid) chk("read response", 32'h1, 32'h0);
	endtask

	// Counts setup, strobe and hold cycles of one access as seen on the pins
	task automatic meas(input bit ss, output int s, t, h, output logic [12:0] a,
		output logic [1:0] b, output bit ok);
		int n;
		bit act, stb;
		s = 0;
		t = 0;
		h = 0;
		n = 0;
		ok = 1;
		do
		begin
			@(posedge aclk);
			n++;
			act = !csn || ben != 4'hF || oe;
			stb = !wen || !ren;
			if (act && stb)
			begin
				t++;
				a = wa;
				b = bl;
			end
			else if (act && t == 0)
				s++;
			else if (act)
				h++;
			if (act && (ss ? csn != !stb : csn)) ok = 0;
		end while ((act || s == 0) && n < 200);
	endtask

	task automatic acc(input bit ss, wr, input logic [31:0] a, d, input logic [3:0] be,
		input int es, tl, th, eh, input logic [1:0] el);
		int s, t, h;
		logic [12:0] w;
		logic [1:0] b, r;
		bit ok;
		axw(ami_pkg::OFF_ADDR, a, r);
		axw(ami_pkg::OFF_WDATA, d, r);
		fork
			axw(ami_pkg::OFF_CMD, {24'h000000, be, 2'h0, wr, 1'b1}, r);
			meas(ss, s, t, h, w, b, ok);
		join
		chk("setup cycles", 32'(es), 32'(s));
		chk("strobe in range", 32'h1, 32'(t >= tl && t <= th));
		chk("hold cycles", 32'(eh), 32'(h));
		chk("word address", 32'(a[14:2]), 32'(w));
		chk("lane select", 32'(el), 32'(b));
		chk("select behaviour", 32'h1, 32'(ok));
	endtask

	// Write timing: setup 1, strobe 2, hold 1; read timing: setup 0, strobe 1, hold 0
	task automatic cfg(input bit ss, ew, input logic [1:0] as);
		logic [31:0] v, d;
		logic [1:0] r;
		v = {ss, ew, 4'h1, 6'h02, 3'h1, 4'h0, 6'h01, 3'h0, 2'h0, as};
		axw(ami_pkg::OFF_TIMING, v, r);
		chk("timing write resp", 32'(ami_pkg::RESP_OKAY), 32'(r));
		axr(ami_pkg::OFF_TIMING, d, r);
		chk("timing readback", v, d);
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		axr(ami_pkg::OFF_TIMING, d, r);
		chk("timing reset", ami_pkg::RST_TIMING, d);
		axr(ami_pkg::OFF_WAIT, d, r);
		chk("wait reset", ami_pkg::RST_WAIT, d);
		axr(8'h1C, d, r);
		chk("unmapped resp", 32'(ami_pkg::RESP_SLVERR), 32'(r));
		axw(8'h1C, 32'h00000000, r);
		chk("unmapped write resp", 32'(ami_pkg::RESP_SLVERR), 32'(r));
		$display("test reset done");
	endtask

	task automatic t_we;
		logic [31:0] d;
		logic [1:0] r;
		cfg(1'b0, 1'b0, ami_pkg::ASIZE_8);
		acc(1'b0, 1'b1, 32'h0000002D, 32'hA5C31E96, 4'hF, 2, 3, 3, 2, 2'h1);
		acc(1'b0, 1'b1, 32'h0000002D, 32'h00007700, 4'h2, 2, 3, 3, 2, 2'h1);
		acc(1'b0, 1'b0, 32'h0000002D, 32'h00000000, 4'hF, 1, 2, 2, 1, 2'h1);
		axr(ami_pkg::OFF_RDATA, d, r);
		chk("byte merge", 32'hA5C37796, d);
		$display("test write strobe mode done");
	endtask

	task automatic t_ss;
		logic [31:0] d;
		logic [1:0] r;
		cfg(1'b1, 1'b0, ami_pkg::ASIZE_16);
		acc(1'b1, 1'b1, 32'h0000002F, 32'h0F1E2D3C, 4'hF, 2, 3, 3, 2, 2'h2);
		cfg(1'b1, 1'b0, 2'h2);
		acc(1'b1, 1'b0, 32'h0000002F, 32'h00000000, 4'hF, 1, 2, 2, 1, 2'h0);
		axr(ami_pkg::OFF_RDATA, d, r);
		chk("select mode read", 32'h0F1E2D3C, d);
		$display("test select strobe mode done");
	endtask

	task automatic t_wait;
		logic [1:0] r;
		wait_len <= 5;
		cfg(1'b0, 1'b1, ami_pkg::ASIZE_8);
		acc(1'b0, 1'b0, 32'h00000010, 32'h00000000, 4'hF, 1, 6, 8, 1, 2'h0);
		axw(ami_pkg::OFF_WAIT, 32'h00000000, r);
		wait_lvl <= 1'b0;
		acc(1'b0, 1'b0, 32'h00000010, 32'h00000000, 4'hF, 1, 6, 8, 1, 2'h0);
		cfg(1'b0, 1'b0, ami_pkg::ASIZE_8);
		acc(1'b0, 1'b0, 32'h00000010, 32'h00000000, 4'hF, 1, 2, 2, 1, 2'h0);
		wait_len <= 0;
		$display("test extended wait done");
	endtask

	// Whole run needs a few hundred cycles; the 20000-cycle limit leaves wide margin
	initial
	begin
		#200000;
		num_errors++;
		conclude();
	end

	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_we();
		t_ss();
		t_wait();
		conclude();
	end
endmodule
